// >>> logic/wtc_pkg.sv
/*
 * Watchdog timer core package: register map, field positions, reset
 * values, clock figures and the shared types.
 * Assumes a 10 MHz system clock and a 32-bit classic Wishbone bus.
 */
package wtc_pkg;

    // ========================================================
    // Clock figures
    localparam int SYS_CLK_HZ        = 10_000_000;
    localparam int LOW_POWER_RC_OSC_HZ           = 32_000;
    localparam int LOW_POWER_RC_OSC_DIV          = SYS_CLK_HZ / LOW_POWER_RC_OSC_HZ;
    localparam logic [8:0] LOW_POWER_RC_OSC_TERM = 9'(LOW_POWER_RC_OSC_DIV - 1);
    localparam int BASE_PERIOD_SHORT_MS = 1;
    localparam int BASE_PERIOD_LONG_MS  = 4;
    localparam int PRE_SHORT = LOW_POWER_RC_OSC_HZ * BASE_PERIOD_SHORT_MS / 1000;
    localparam int PRE_LONG  = LOW_POWER_RC_OSC_HZ * BASE_PERIOD_LONG_MS / 1000;
    localparam logic [6:0] PRE_SHORT_TERM = 7'(PRE_SHORT - 1);
    localparam logic [6:0] PRE_LONG_TERM  = 7'(PRE_LONG - 1);

    // ========================================================
    // Register map (byte addresses)
    localparam logic [7:0] OFF_RESET_CTRL = 8'h00;
    localparam logic [7:0] OFF_INT_STAT   = 8'h04;
    localparam logic [7:0] OFF_INT_MASK   = 8'h08;
    localparam logic [7:0] OFF_STATUS     = 8'h0C;

    // ========================================================
    // Field positions
    localparam int RC_SOFT_EN_BIT = 5;
    localparam int RC_TIMEOUT_BIT = 4;
    localparam int RC_SLEEP_BIT   = 3;
    localparam int RC_IDLE_BIT    = 2;
    localparam int CFG_FORCE_BIT  = 7;
    localparam int CFG_PRE_BIT    = 4;
    localparam int EV_TIMEOUT_BIT = 0;
    localparam int EV_WAKE_BIT    = 1;

    // ========================================================
    // Reset values
    localparam logic [7:0] CFG_RESET      = 8'h00;
    localparam logic [1:0] INT_MASK_RESET = 2'h0;

    // ========================================================
    // Types
    typedef struct packed {
        logic       force_en;
        logic [1:0] unused;
        logic       pre_sel;
        logic [3:0] post_field;
    } wtc_cfg_t;

    typedef struct packed {
        logic wake;
        logic timeout;
    } wtc_ev_t;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_IDLE
    } wtc_mode_t;

endpackage

// >>> logic/wtc_low_power_rc_osc_tick.sv
/*
 * Low-power RC clock stand-in: a one-cycle enable at about 32 kHz.
 * Assumes sys_clk at 10 MHz; the divider runs only while osc_on is high.
 */
`timescale 1ns/10ps
`default_nettype none

module wtc_low_power_rc_osc_tick (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic osc_on,
    output logic      tick
);

    logic [8:0] div_q;

    // ========================================================
    // Divider
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 9'h000;
            tick  <= 1'b0;
        end else if (!osc_on) begin
            div_q <= 9'h000;
            tick  <= 1'b0;
        end else begin
            tick  <= (div_q == wtc_pkg::LOW_POWER_RC_OSC_TERM);
            div_q <= (div_q == wtc_pkg::LOW_POWER_RC_OSC_TERM) ? 9'h000 : div_q + 9'h001;
        end
    end

    a_low_power_rc_osc_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !osc_on |=> !tick)
        else $error("tick while oscillator off");
    a_low_power_rc_osc_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tick |=> !tick)
        else $error("tick longer than one cycle");

endmodule // wtc_low_power_rc_osc_tick

`default_nettype wire

// >>> logic/wtc_postscaler.sv
/*
 * Watchdog postscaler: counts prescaler ticks, 1:1 up to 1:32,768.
 * Assumes tick_in is a one-cycle enable and clr outranks it.
 */
`timescale 1ns/10ps
`default_nettype none

module wtc_postscaler (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       clr,
    input  wire logic       tick_in,
    input  wire logic [3:0] field,
    output logic            tick_out
);

    logic [14:0] cnt_q;

    // code n gives 2 to the n
    function automatic logic [14:0] post_term(input logic [3:0] f);
        post_term = 15'((16'h0001 << f) - 16'h0001);
    endfunction

    assign tick_out = tick_in && !clr && (cnt_q == post_term(field));

    // ========================================================
    // Counter
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 15'h0000;
        end else if (clr) begin
            cnt_q <= 15'h0000;
        end else if (tick_in) begin
            cnt_q <= tick_out ? 15'h0000 : cnt_q + 15'h0001;
        end
    end

    a_post_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tick_out |=> cnt_q == 15'h0000)
        else $error("postscaler did not wrap");
    a_post_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cnt_q <= post_term(field))
        else $error("postscaler count above ratio");

endmodule // wtc_postscaler

`default_nettype wire

// >>> logic/wtc_core.sv
/*
 * Watchdog timer core: prescaler, postscaler, power-save tracking,
 * reset control flags and a classic Wishbone register slave.
 * Assumes the core drives the instruction strobes on sys_clk as
 * one-cycle pulses, and that the config word comes from fuse pins.
 */
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

module wtc_core (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [7:0]  wd_config_word,
    input  wire logic        power_save_instr,
    input  wire logic        power_save_idle,
    input  wire logic        wd_clear_instr,
    input  wire logic        clk_switch_done,
    input  wire logic        ext_wake,
    output logic             low_power_rc_osc,
    output logic             wd_reset_req,
    output logic             wd_wake,
    output logic [1:0]       power_mode,
    output logic             irq
);

    // ========================================================
    // Declarations
    logic [7:0]          cfg_meta_q;
    logic [7:0]          cfg_q;
    wtc_pkg::wtc_cfg_t   cfg;
    wtc_pkg::wtc_mode_t  mode_q;
    wtc_pkg::wtc_ev_t    ev;
    logic                soft_en_q;
    logic                timeout_flag_q;
    logic                sleep_flag_q;
    logic                idle_flag_q;
    logic [1:0]          int_stat_q;
    logic [1:0]          int_mask_q;
    logic [6:0]          pre_cnt_q;
    logic                wd_run;
    logic                low_power_rc_osc_tick;
    logic                pre_tick;
    logic                post_tick;
    logic                tmo;
    logic                enter_ps;
    logic                exit_ps;
    logic                clr;
    logic                post_clr;
    logic                bus_acc;
    logic                bus_wr;
    logic                wr_rc;
    logic                wr_stat;
    logic                wr_mask;

    // Prescaler terminal count for the selected divide
    function automatic logic [6:0] pre_term(input logic sel);
        pre_term = sel ? wtc_pkg::PRE_LONG_TERM : wtc_pkg::PRE_SHORT_TERM;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ========================================================
    // Fuse word synchroniser
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_meta_q <= wtc_pkg::CFG_RESET;
            cfg_q      <= wtc_pkg::CFG_RESET;
        end else begin
            cfg_meta_q <= wd_config_word;
            cfg_q      <= cfg_meta_q;
        end
    end

    assign cfg = wtc_pkg::wtc_cfg_t'(cfg_q);

    // ========================================================
    // Enable and oscillator
    // enable selection
    assign wd_run = cfg.force_en || soft_en_q;
    assign low_power_rc_osc = wd_run;

    wtc_low_power_rc_osc_tick u_low_power_rc_osc (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .osc_on  (low_power_rc_osc),
        .tick    (low_power_rc_osc_tick)
    );

    // ========================================================
    // Clear sources
    assign enter_ps = (mode_q == wtc_pkg::MODE_RUN) && power_save_instr;
    assign exit_ps  = (mode_q != wtc_pkg::MODE_RUN) && (tmo || ext_wake);
    // Kept free of tmo so the time-out cannot gate its own clear
    assign post_clr = clk_switch_done || enter_ps || !wd_run
                   || ((mode_q != wtc_pkg::MODE_RUN) && ext_wake)
                   || ((mode_q == wtc_pkg::MODE_RUN) && wd_clear_instr);
    assign clr = clk_switch_done || enter_ps || exit_ps
              || ((mode_q == wtc_pkg::MODE_RUN) && wd_clear_instr);

    // ========================================================
    // Prescaler
    // divide by 32 or 128
    assign pre_tick = wd_run && low_power_rc_osc_tick && (pre_cnt_q == pre_term(cfg.pre_sel));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_q <= 7'h00;
        end else if (clr || !wd_run) begin
            pre_cnt_q <= 7'h00;
        end else if (low_power_rc_osc_tick) begin
            pre_cnt_q <= pre_tick ? 7'h00 : pre_cnt_q + 7'h01;
        end
    end

    wtc_postscaler u_post (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .clr      (post_clr),
        .tick_in  (pre_tick),
        .field    (cfg.post_field),
        .tick_out (post_tick)
    );

    assign tmo = post_tick;

    // ========================================================
    // Power mode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= wtc_pkg::MODE_RUN;
        end else begin
            case (mode_q)
                wtc_pkg::MODE_RUN: begin
                    if (power_save_instr) begin
                        mode_q <= power_save_idle ? wtc_pkg::MODE_IDLE
                                                  : wtc_pkg::MODE_SLEEP;
                    end
                end
                wtc_pkg::MODE_SLEEP, wtc_pkg::MODE_IDLE: begin
                    if (exit_ps) begin
                        mode_q <= wtc_pkg::MODE_RUN;
                    end
                end
                default: begin
                    mode_q <= wtc_pkg::MODE_RUN;
                end
            endcase
        end
    end

    assign power_mode = mode_q;

    // ========================================================
    // Reset request and wake outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_reset_req <= 1'b0;
            wd_wake      <= 1'b0;
        end else begin
            wd_reset_req <= tmo && (mode_q == wtc_pkg::MODE_RUN);
            wd_wake      <= exit_ps;
        end
    end

    // ========================================================
    // Wishbone decode
    assign bus_acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr  = bus_acc && wb_we_i && wb_sel_i[0];
    assign wr_rc   = bus_wr && hit(wb_adr_i, wtc_pkg::OFF_RESET_CTRL);
    assign wr_stat = bus_wr && hit(wb_adr_i, wtc_pkg::OFF_INT_STAT);
    assign wr_mask = bus_wr && hit(wb_adr_i, wtc_pkg::OFF_INT_MASK);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_acc;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_acc && !wb_we_i) begin
            wb_dat_o <= 32'h0000_0000;
            if (hit(wb_adr_i, wtc_pkg::OFF_RESET_CTRL)) begin
                wb_dat_o[wtc_pkg::RC_SOFT_EN_BIT] <= soft_en_q;
                wb_dat_o[wtc_pkg::RC_TIMEOUT_BIT] <= timeout_flag_q;
                wb_dat_o[wtc_pkg::RC_SLEEP_BIT]   <= sleep_flag_q;
                wb_dat_o[wtc_pkg::RC_IDLE_BIT]    <= idle_flag_q;
            end else if (hit(wb_adr_i, wtc_pkg::OFF_INT_STAT)) begin
                wb_dat_o[1:0] <= int_stat_q;
            end else if (hit(wb_adr_i, wtc_pkg::OFF_INT_MASK)) begin
                wb_dat_o[1:0] <= int_mask_q;
            end else if (hit(wb_adr_i, wtc_pkg::OFF_STATUS)) begin
                wb_dat_o[22:16] <= pre_cnt_q;
                wb_dat_o[15:8]  <= cfg_q;
                wb_dat_o[3]     <= low_power_rc_osc;
                wb_dat_o[2]     <= wd_run;
                wb_dat_o[1:0]   <= mode_q;
            end
        end
    end

    // ========================================================
    // Reset control flags
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_en_q <= 1'b0;
        end else if (wr_rc) begin
            soft_en_q <= wb_dat_i[wtc_pkg::RC_SOFT_EN_BIT]
                      || (cfg.force_en && soft_en_q);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_flag_q <= 1'b0;
        end else if (tmo) begin
            timeout_flag_q <= 1'b1;
        end else if (wr_rc && !wb_dat_i[wtc_pkg::RC_TIMEOUT_BIT]) begin
            timeout_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_flag_q <= 1'b0;
            idle_flag_q  <= 1'b0;
        end else begin
            if (enter_ps && !power_save_idle) begin
                sleep_flag_q <= 1'b1;
            end else if (wr_rc && !wb_dat_i[wtc_pkg::RC_SLEEP_BIT]) begin
                sleep_flag_q <= 1'b0;
            end
            if (enter_ps && power_save_idle) begin
                idle_flag_q <= 1'b1;
            end else if (wr_rc && !wb_dat_i[wtc_pkg::RC_IDLE_BIT]) begin
                idle_flag_q <= 1'b0;
            end
        end
    end

    // ========================================================
    // Interrupt status and mask
    assign ev.timeout = tmo;
    assign ev.wake    = exit_ps;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_stat_q <= 2'h0;
        end else begin
            int_stat_q <= (int_stat_q & ~(wr_stat ? wb_dat_i[1:0] : 2'h0)) | ev;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_mask_q <= wtc_pkg::INT_MASK_RESET;
        end else if (wr_mask) begin
            int_mask_q <= wb_dat_i[1:0];
        end
    end

    assign irq = |(int_stat_q & int_mask_q);

    // ========================================================
    // Assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_enter_sleep;
        mode_q == wtc_pkg::MODE_RUN && power_save_instr && !power_save_idle;
    endsequence

    sequence s_ps_timeout;
        mode_q != wtc_pkg::MODE_RUN && tmo;
    endsequence

    a_osc_on_enable: assert property (wd_run |-> low_power_rc_osc)
        else $error("watchdog enabled with oscillator off");

    a_pre_terminal: assert property (pre_tick |->
        pre_cnt_q == (cfg.pre_sel ? 7'h7F : 7'h1F))
        else $error("prescaler wrapped at wrong count");

    a_clk_switch_clr: assert property (clk_switch_done |=> pre_cnt_q == 7'h00)
        else $error("clock switch did not clear prescaler");

    a_ps_entry_clr: assert property (s_enter_sleep |=>
        pre_cnt_q == 7'h00 && mode_q == wtc_pkg::MODE_SLEEP && sleep_flag_q)
        else $error("power-save entry mishandled");

    a_ps_exit_clr: assert property (exit_ps |=>
        pre_cnt_q == 7'h00 && mode_q == wtc_pkg::MODE_RUN)
        else $error("power-save exit mishandled");

    a_kick_clr: assert property (mode_q == wtc_pkg::MODE_RUN && wd_clear_instr
        |=> pre_cnt_q == 7'h00)
        else $error("clear instruction ignored");

    a_sleep_counts: assert property (mode_q != wtc_pkg::MODE_RUN && wd_run
        && low_power_rc_osc_tick && !clr && !pre_tick |=> pre_cnt_q == $past(pre_cnt_q) + 7'h01)
        else $error("prescaler stalled in power-save");

    a_ps_wake: assert property (s_ps_timeout |=>
        wd_wake && !wd_reset_req ##1 !wd_wake)
        else $error("power-save time-out did not wake");

    a_force_on: assert property (cfg.force_en |-> wd_run)
        else $error("forced watchdog not running");

    a_force_keep: assert property (cfg.force_en && soft_en_q && wr_rc
        |=> soft_en_q)
        else $error("forced soft enable was cleared");

    a_soft_gate: assert property (!cfg.force_en && !soft_en_q
        |-> !wd_run ##1 pre_cnt_q == 7'h00)
        else $error("watchdog ran while disabled");

    a_flag_sticky: assert property (tmo |=> timeout_flag_q [*2])
        else $error("time-out flag not sticky");

    a_run_reset: assert property (mode_q == wtc_pkg::MODE_RUN && tmo
        |=> wd_reset_req ##1 !wd_reset_req)
        else $error("run-mode time-out gave no reset");

    a_irq_level: assert property (int_stat_q[0] && int_mask_q[0] |-> irq)
        else $error("unmasked status without interrupt");

endmodule // wtc_core

`default_nettype wire

// >>> tb/tb_wtc_core.sv
/*
 * Self-checking bench for wtc_core: reset values, register access,
 * run-mode time-out and clears, sleep and idle wake, force fuse and
 * the long prescaler.
 * Assumes the logic/ files are compiled first; one 10 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_wtc_core;
    logic        sys_clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic        ack;
    logic [7:0]  cfg;
    logic        ps;
    logic        ps_idle;
    logic        kick;
    logic        sw_done;
    logic        osc;
    logic        rst_req;
    logic        wake;
    logic        irq;
    logic [1:0]  mode;
    logic [31:0] rd;
    int          fail_count;
    int          checks;
    int          n;
    int          rst_cnt;
    int          wake_cnt;

    wtc_core i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_sel_i(4'hF),
        .wb_dat_o(dat_r), .wb_ack_o(ack), .wd_config_word(cfg),
        .power_save_instr(ps), .power_save_idle(ps_idle),
        .wd_clear_instr(kick), .clk_switch_done(sw_done), .ext_wake(1'b0),
        .low_power_rc_osc(osc), .wd_reset_req(rst_req), .wd_wake(wake),
        .power_mode(mode), .irq(irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ========================================================
    // Pulse counters for reset requests and wakes
    always @(posedge sys_clk) begin
        if (rst_req === 1'b1) rst_cnt++;
        if (wake === 1'b1) wake_cnt++;
    end

    // ========================================================
    // Shared tasks
    task automatic summarize();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask

    task automatic lost(input string m);
        fail_count++;
        $display("BAD %0t %s timed out", $time, m);
        summarize();
    endtask

    task automatic chk_rng(input int lo, input int hi, input string m);
        chk({31'h0, (n >= lo && n <= hi)}, 32'h1, m);
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        @(posedge sys_clk);
        while (ack !== 1'b1) begin
            k++;
            if (k > 20) lost("bus");
            @(posedge sys_clk);
        end
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
        bus(1'b0, a, 32'h0);
        chk(rd, e, m);
    endtask

    // Selector: 0 clear instruction, 1 clock switch, 2 power save
    task automatic pulse(input int s);
        if (s == 0) kick <= 1'b1;
        else if (s == 1) sw_done <= 1'b1;
        else ps <= 1'b1;
        @(posedge sys_clk);
        kick <= 1'b0;
        sw_done <= 1'b0;
        ps <= 1'b0;
    endtask

    task automatic wait_ev(input logic want_wake, input int lim);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (n > lim) lost("event wait");
        end while ((want_wake ? wake : rst_req) !== 1'b1);
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
    endtask

    // ========================================================
    // Scenarios
    task automatic t_reset();
        rchk(8'h00, 32'h0, "reset ctrl after reset");
        rchk(8'h04, 32'h0, "int stat after reset");
        rchk(8'h08, 32'h0, "int mask after reset");
        rchk(8'hF0, 32'h0, "unmapped read");
        chk({31'h0, osc}, 32'h1 & {31'h0, cfg[7]}, "osc after reset");
        $display("reset test done");
    endtask

    task automatic t_run();
        bus(1'b1, 8'hF0, 32'hFFFF_FFFF);
        bus(1'b1, 8'h08, 32'h1);
        bus(1'b1, 8'h00, 32'h20);
        chk({31'h0, osc}, 32'h1, "osc on with soft enable");
        rchk(8'h0C, {8'h0, 8'h0, cfg, 8'hC}, "status running");
        rst_cnt = 0;
        for (int s = 0; s < 2; s++) begin
            pulse(s);
            repeat (25 * 312) @(posedge sys_clk);
        end
        chk(rst_cnt, 32'h0, "kicks keep reset away");
        pulse(0);
        wait_ev(1'b0, 34 * 312);
        chk_rng(31 * 312, 33 * 312, "short base period");
        chk(wake_cnt, 32'h0, "no wake in run");
        rchk(8'h00, 32'h30, "time-out flag set");
        chk({31'h0, irq}, 32'h1, "irq on time-out");
        bus(1'b1, 8'h08, 32'h0);
        chk({31'h0, irq}, 32'h0, "irq masked");
        bus(1'b1, 8'h08, 32'h3);
        rchk(8'h04, 32'h1, "int stat time-out");
        bus(1'b1, 8'h04, 32'h1);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        rchk(8'h00, 32'h30, "flag stays set");
        bus(1'b1, 8'h00, 32'h20);
        rchk(8'h00, 32'h20, "flag cleared");
        $display("run test done");
    endtask

    task automatic t_save(input logic idl);
        int r0;
        r0 = rst_cnt;
        wake_cnt = 0;
        ps_idle <= idl;
        pulse(2);
        @(posedge sys_clk);
        chk({30'h0, mode}, idl ? 32'h2 : 32'h1, "power mode");
        repeat (16 * 312) @(posedge sys_clk);
        pulse(0);
        wait_ev(1'b1, 20 * 312);
        n = n + 16 * 312 + 2;
        chk_rng(31 * 312, 33 * 312, "wake after period");
        chk({30'h0, mode}, 32'h0, "back in run");
        chk(rst_cnt, r0, "no reset on wake");
        rchk(8'h00, idl ? 32'h34 : 32'h38, "save and time-out flags set");
        rchk(8'h04, 32'h3, "int stat wake and time-out");
        bus(1'b1, 8'h04, 32'h3);
        bus(1'b1, 8'h00, 32'h20);
        rchk(8'h00, 32'h20, "save flag cleared");
        $display("power save test done");
    endtask

    task automatic t_force();
        cfg <= 8'h80;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, osc}, 32'h1, "forced osc on");
        bus(1'b1, 8'h00, 32'h20);
        bus(1'b1, 8'h00, 32'h0);
        rchk(8'h00, 32'h20, "soft clear ignored");
        chk({31'h0, osc}, 32'h1, "osc kept");
        cfg <= 8'h90;
        repeat (3) @(posedge sys_clk);
        rchk(8'h0C, 32'h0000_900C, "status fuse word");
        pulse(0);
        wait_ev(1'b0, 130 * 312);
        chk_rng(127 * 312, 129 * 312, "long base period");
        $display("force test done");
    endtask

    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h0;
        dat_w = 32'h0;
        cfg = 8'h00;
        ps = 1'b0;
        ps_idle = 1'b0;
        kick = 1'b0;
        sw_done = 1'b0;
        fail_count = 0;
        checks = 0;
        rst_cnt = 0;
        wake_cnt = 0;
        do_reset();
        t_reset();
        t_run();
        t_save(1'b0);
        t_save(1'b1);
        do_reset();
        t_reset();
        t_force();
        summarize();
    end
endmodule // tb_wtc_core

`default_nettype wire
